/* core/cbp_consts.svh */
// Purpose: constants for the coprocessor busy-wait and privilege port
// Assumes: one core clock, synchronous active-high reset
// Notes: handshake codes are shared by decode and execute buses
//
// Behaviour
// - non-move mode change switches after first execute
// - status-register move switches after second execute
// - only decode response at advance is used
// - interrupt while busy-waiting drops pass qualifier, abandons
// - handshake codes: absent 10, wait 00, go 01, last 11
// - busy-wait: absent gives undefined trap, go/last proceeds
`ifndef CBP_CONSTS_SVH
`define CBP_CONSTS_SVH
`define CBP_HS_ABSENT 2'h2
`define CBP_HS_WAIT 2'h0
`define CBP_HS_GO 2'h1
`define CBP_HS_LAST 2'h3
`define CBP_MODE_STEP_PLAIN 2'h1
`define CBP_MODE_STEP_MOVE 2'h2
`endif

/* core/cbp_pkg.sv */
// Purpose: types for the coprocessor busy-wait and privilege port
// Assumes: used with cbp_consts.svh
// Notes: one-hot state codes
package cbp_pkg;
  typedef enum logic [3:0] {
    CBP_IDLE = 4'h1,
    CBP_BUSY = 4'h2,
    CBP_RUN = 4'h4,
    CBP_DONE = 4'h8
  } cbp_state_type;
endpackage

/* core/cbp_port.sv */
// Purpose: core-side coprocessor handshake, busy-wait and privilege tracking
// Assumes: handshake buses and interrupt come from other clock domains
// Notes: pipeline supplies advance, execute and mode-change strobes
`timescale 1ns/100ps
`include "cbp_consts.svh"
module cbp_port (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire logic [1:0] decode_handshake_bus_i,
  input wire logic [1:0] execute_handshake_bus_i,
  input wire logic irq_i,
  input wire logic advance_i,
  input wire logic cond_pass_i,
  input wire logic mode_change_i,
  input wire logic status_register_move_i,
  input wire logic new_priv_i,
  output logic cp_privilege_indication_o,
  output logic execute_pass_qualifier_o,
  output logic stall_o,
  output logic undef_trap_o,
  output logic commit_o,
  output logic abandon_o
);

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [1:0] de_s1_r, de_s2_r, ex_s1_r, ex_s2_r;
  logic irq_s1_r, irq_s2_r;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      de_s1_r <= `CBP_HS_ABSENT;
      de_s2_r <= `CBP_HS_ABSENT;
      ex_s1_r <= `CBP_HS_ABSENT;
      ex_s2_r <= `CBP_HS_ABSENT;
      irq_s1_r <= 1'b0;
      irq_s2_r <= 1'b0;
    end
    else if (ce_i)
    begin
      de_s1_r <= decode_handshake_bus_i;
      de_s2_r <= de_s1_r;
      ex_s1_r <= execute_handshake_bus_i;
      ex_s2_r <= ex_s1_r;
      irq_s1_r <= irq_i;
      irq_s2_r <= irq_s1_r;
    end
  end

  function automatic logic hs_proceed(input logic [1:0] hs);
    hs_proceed = (hs == `CBP_HS_GO) || (hs == `CBP_HS_LAST);
  endfunction

  // ----------------------------------------
  // handshake state machine
  // ----------------------------------------
  cbp_pkg::cbp_state_type state_r;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= cbp_pkg::CBP_IDLE;
      execute_pass_qualifier_o <= 1'b0;
      stall_o <= 1'b0;
      undef_trap_o <= 1'b0;
      commit_o <= 1'b0;
      abandon_o <= 1'b0;
    end
    else if (ce_i)
    begin
      undef_trap_o <= 1'b0;
      commit_o <= 1'b0;
      abandon_o <= 1'b0;
      case (state_r)
        cbp_pkg::CBP_IDLE:
        begin
          // decode answer counts only as instruction advances
          if (advance_i)
          begin
            execute_pass_qualifier_o <= cond_pass_i;
            if (!cond_pass_i)
              state_r <= cbp_pkg::CBP_IDLE;
            else if (de_s2_r == `CBP_HS_ABSENT)
            begin
              // leave through done so the qualifier drops again
              undef_trap_o <= 1'b1;
              state_r <= cbp_pkg::CBP_DONE;
            end
            else if (de_s2_r == `CBP_HS_WAIT)
            begin
              stall_o <= 1'b1;
              state_r <= cbp_pkg::CBP_BUSY;
            end
            else
            begin
              commit_o <= 1'b1;
              state_r <= cbp_pkg::CBP_DONE;
            end
          end
        end
        cbp_pkg::CBP_BUSY:
        begin
          // interrupt wins over a late go for latency
          if (irq_s2_r)
          begin
            execute_pass_qualifier_o <= 1'b0;
            abandon_o <= 1'b1;
            stall_o <= 1'b0;
            state_r <= cbp_pkg::CBP_DONE;
          end
          else if (ex_s2_r == `CBP_HS_ABSENT)
          begin
            undef_trap_o <= 1'b1;
            execute_pass_qualifier_o <= 1'b0;
            stall_o <= 1'b0;
            state_r <= cbp_pkg::CBP_DONE;
          end
          else if (hs_proceed(ex_s2_r))
          begin
            commit_o <= 1'b1;
            stall_o <= 1'b0;
            state_r <= cbp_pkg::CBP_DONE;
          end
        end
        cbp_pkg::CBP_DONE:
        begin
          execute_pass_qualifier_o <= 1'b0;
          state_r <= cbp_pkg::CBP_IDLE;
        end
        default:
        begin
          state_r <= cbp_pkg::CBP_IDLE;
          stall_o <= 1'b0;
          execute_pass_qualifier_o <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------
  // privilege indication
  // ----------------------------------------
  logic [1:0] mode_cnt_r;
  logic pend_priv_r;

  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      mode_cnt_r <= 2'h0;
      pend_priv_r <= 1'b1;
      cp_privilege_indication_o <= 1'b1;
    end
    else if (ce_i)
    begin
      if (mode_change_i)
      begin
        pend_priv_r <= new_priv_i;
        mode_cnt_r <= status_register_move_i ? `CBP_MODE_STEP_MOVE
                                             : `CBP_MODE_STEP_PLAIN;
      end
      else if (mode_cnt_r != 2'h0)
      begin
        mode_cnt_r <= mode_cnt_r - 2'h1;
        if (mode_cnt_r == 2'h1)
          cp_privilege_indication_o <= pend_priv_r;
      end
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  irq_drops_pass_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && state_r == cbp_pkg::CBP_BUSY && irq_s2_r |=> !execute_pass_qualifier_o && abandon_o)
    else $error("interrupt did not abandon");
  absent_trap_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && state_r == cbp_pkg::CBP_BUSY && !irq_s2_r && ex_s2_r == `CBP_HS_ABSENT
    |=> undef_trap_o)
    else $error("absent in busy-wait gave no trap");
  go_commit_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && state_r == cbp_pkg::CBP_BUSY && !irq_s2_r && hs_proceed(ex_s2_r)
    |=> commit_o && !stall_o)
    else $error("go in busy-wait did not proceed");
  decode_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && state_r == cbp_pkg::CBP_IDLE && !advance_i |=> !commit_o && !undef_trap_o)
    else $error("decode answer used before advance");
  plain_switch_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && mode_change_i && !status_register_move_i ##1 ce_i && !mode_change_i
    |=> cp_privilege_indication_o == $past(pend_priv_r))
    else $error("plain mode change late");
  move_switch_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && mode_change_i && status_register_move_i ##1 (ce_i && !mode_change_i) [*2]
    |=> cp_privilege_indication_o == $past(pend_priv_r))
    else $error("move mode change late");
  move_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && mode_change_i && status_register_move_i |=> $stable(cp_privilege_indication_o))
    else $error("move mode change early");
  wait_stall_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && state_r == cbp_pkg::CBP_IDLE && advance_i && cond_pass_i && de_s2_r == `CBP_HS_WAIT
    |=> stall_o && execute_pass_qualifier_o)
    else $error("wait did not stall");
  absent_decode_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && state_r == cbp_pkg::CBP_IDLE && advance_i && cond_pass_i
    && de_s2_r == `CBP_HS_ABSENT |=> undef_trap_o ##1 (!ce_i || !execute_pass_qualifier_o))
    else $error("absent at decode gave no trap");
  cond_fail_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    ce_i && state_r == cbp_pkg::CBP_IDLE && advance_i && !cond_pass_i
    |=> !execute_pass_qualifier_o && !commit_o && !stall_o)
    else $error("failed condition still answered");
  busy_pass_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    state_r == cbp_pkg::CBP_BUSY |-> execute_pass_qualifier_o && stall_o)
    else $error("busy-wait without pass qualifier");
  priv_still_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !mode_change_i && mode_cnt_r == 2'h0 |=> $stable(cp_privilege_indication_o))
    else $error("privilege moved without mode change");
  one_outcome_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
    !(commit_o && undef_trap_o) && !(commit_o && abandon_o))
    else $error("two outcomes at once");
  busy_wait_c: cover property (@(posedge clk_i) stall_o [*3] ##1 commit_o);
  decode_go_c: cover property (@(posedge clk_i) advance_i && de_s2_r == `CBP_HS_GO);
  abandon_c: cover property (@(posedge clk_i) stall_o ##1 abandon_o);
  trap_c: cover property (@(posedge clk_i) stall_o ##1 undef_trap_o);
  move_c: cover property (@(posedge clk_i) mode_change_i && status_register_move_i);

endmodule

/* verif/cbp_cop_model.sv */
// Purpose: coprocessor follower model for the busy-wait port
// Assumes: shares the core clock
// Notes: holds wait for wait_n_i cycles of pass, then the final answer
`timescale 1ns/100ps
`include "cbp_consts.svh"
module cbp_cop_model (
  input wire logic clk_i,
  input wire logic sys_rst_i,
  input wire logic [1:0] de_code_i,
  input wire logic [1:0] ex_code_i,
  input wire logic [7:0] wait_n_i,
  input wire logic pass_i,
  output logic [1:0] de_bus_o,
  output logic [1:0] ex_bus_o,
  output logic [7:0] commits_o,
  output logic [7:0] aborts_o
);
  logic [7:0] cnt_r;
  logic done_r;
  assign de_bus_o = de_code_i;
  assign ex_bus_o = (cnt_r < wait_n_i) ? `CBP_HS_WAIT : ex_code_i;
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i || !pass_i)
    begin
      cnt_r <= 8'h00;
      done_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_r + ((cnt_r < wait_n_i) ? 8'h01 : 8'h00);
      done_r <= done_r | ex_bus_o[0];
    end
  end
  always_ff @(posedge clk_i)
  begin
    if (sys_rst_i)
    begin
      commits_o <= 8'h00;
      aborts_o <= 8'h00;
    end
    else
    begin
      // commit count rises only on pass with go or last; abort count only on pass dropping mid-wait
      if (pass_i && ex_bus_o[0] && !done_r)
        commits_o <= commits_o + 8'h01;
      if (!pass_i && cnt_r != 8'h00 && ex_bus_o == `CBP_HS_WAIT && de_code_i == `CBP_HS_WAIT)
        aborts_o <= aborts_o + 8'h01;
    end
  end
endmodule

/* verif/coproc_busywait_privilege_tb.sv */
// Purpose: self-checking bench for the busy-wait and privilege port
// Assumes: inputs change on the falling edge
// Notes: ce_i tied high
`timescale 1ns/100ps
`include "cbp_consts.svh"
module coproc_busywait_privilege_tb;
  logic clk_i = 0, sys_rst_i = 1, irq_i = 0, adv = 0, cond = 0, mc = 0, mv = 0, np = 0;
  logic [1:0] de_c = `CBP_HS_ABSENT, ex_c = `CBP_HS_ABSENT, de_b, ex_b;
  logic [7:0] wn = 8'h04, n_com, n_ab;
  logic priv, pass, stall, undef, com, ab;
  int n_errors = 0, comparisons = 0;
  initial forever #5 clk_i = ~clk_i;
  cbp_port u_cbp_port (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(1'b1),
    .decode_handshake_bus_i(de_b), .execute_handshake_bus_i(ex_b), .irq_i(irq_i),
    .advance_i(adv), .cond_pass_i(cond), .mode_change_i(mc), .status_register_move_i(mv),
    .new_priv_i(np), .cp_privilege_indication_o(priv), .execute_pass_qualifier_o(pass),
    .stall_o(stall), .undef_trap_o(undef), .commit_o(com), .abandon_o(ab));
  cbp_cop_model u_cbp_cop_model (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .de_code_i(de_c),
    .ex_code_i(ex_c), .wait_n_i(wn), .pass_i(pass), .de_bus_o(de_b), .ex_bus_o(ex_b),
    .commits_o(n_com), .aborts_o(n_ab));
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (e !== g)
    begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic priv_step(input logic m, input logic p);
    logic old;
    old = priv;
    @(negedge clk_i);
    mc = 1;
    mv = m;
    np = p;
    @(negedge clk_i);
    mc = 0;
    if (m)
      @(negedge clk_i);
    chk("priv_hold", {7'h00, old}, {7'h00, priv});
    @(negedge clk_i);
    chk("priv_new", {7'h00, p}, {7'h00, priv});
  endtask
  task automatic op(input logic [1:0] de, input logic [1:0] ex, input logic c,
    input logic i, input logic [3:0] exp);
    logic [3:0] got;
    int k;
    got = 4'h0;
    @(negedge clk_i);
    de_c = `CBP_HS_ABSENT;
    @(negedge clk_i);
    de_c = de;
    ex_c = ex;
    wn = i ? 8'hC8 : 8'h04;
    repeat (3) @(negedge clk_i);
    adv = 1;
    cond = c;
    @(negedge clk_i);
    adv = 0;
    for (k = 0; k < 300 && got[2:0] == 3'h0; k++)
    begin
      got[3] = got[3] | (stall === 1'b1);
      if (i && stall === 1'b1)
        irq_i = 1;
      got[2:0] = {com === 1'b1, undef === 1'b1, ab === 1'b1};
      if (got[2:0] == 3'h0)
        @(negedge clk_i);
    end
    irq_i = 0;
    chk("outcome", {4'h0, exp}, {4'h0, got});
  endtask
  task automatic stop_test();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (5) @(negedge clk_i);
    sys_rst_i = 0;
    chk("priv_reset", 8'h01, {7'h00, priv});
    priv_step(0, 0);
    priv_step(1, 1);
    priv_step(1, 0);
    priv_step(0, 1);
    op(`CBP_HS_GO, `CBP_HS_ABSENT, 1, 0, 4'h4);
    op(`CBP_HS_LAST, `CBP_HS_ABSENT, 1, 0, 4'h4);
    op(`CBP_HS_ABSENT, `CBP_HS_GO, 1, 0, 4'h2);
    op(`CBP_HS_WAIT, `CBP_HS_GO, 1, 0, 4'hC);
    op(`CBP_HS_WAIT, `CBP_HS_LAST, 1, 0, 4'hC);
    op(`CBP_HS_WAIT, `CBP_HS_ABSENT, 1, 0, 4'hA);
    op(`CBP_HS_WAIT, `CBP_HS_GO, 1, 1, 4'h9);
    op(`CBP_HS_GO, `CBP_HS_GO, 0, 0, 4'h0);
    chk("cop_commits", 8'h02, n_com);
    chk("cop_aborts", 8'h01, n_ab);
    stop_test();
  end
endmodule
